/* File: cpu_regs.svh */
// Constants for the subtract, trap, test and transfer instruction core
`ifndef CPU_REGS_SVH
`define CPU_REGS_SVH
// How it works
// - minus_op loads A with A minus M and updates V, N, Z and C.
// - soft_trap_op advances PC, pushes five bytes, sets I, loads PC from vector.
// - zero_neg_check_op sets N and Z from A, X or M, clears V, keeps C.
// - absolute_mode takes two operand bytes, high first, as the full address.
// - index_word_offset_mode adds a two-byte offset, high first, to the index pair.
// - index_byte_offset_mode adds one unsigned offset byte to the index pair.
// - stack_byte_offset_mode adds one offset byte to the stack pointer, after a prefix.
// - index_postinc_mode addresses at the index pair, then increments it.
// - index_byte_offset_postinc_mode addresses index pair plus byte, then increments it.
// - index_postinc_to_page_mode moves from index pair to page zero, then increments.
// - page_to_index_postinc_mode moves from page zero to index pair, then increments.
// - literal_to_page_mode stores an inline literal byte at a page-zero address.
// - page_to_page_mode copies one page-zero byte to another page-zero byte.
// - compare-and-branch with page-zero operand fetches address byte, then branch offset.

// Prefix byte for stack-relative forms
`define OPC_PREFIX 8'h9E
// Subtract row
`define OPC_MINUS_LIT 8'hA0
`define OPC_MINUS_PAGE 8'hB0
`define OPC_MINUS_ABS 8'hC0
`define OPC_MINUS_IDXW 8'hD0
`define OPC_MINUS_IDXB 8'hE0
`define OPC_MINUS_IDX 8'hF0
`define OPC_MINUS_STKB 8'hE0
`define OPC_MINUS_STKW 8'hD0
// Zero and negative check row
`define OPC_ZN_PAGE 8'h3D
`define OPC_ZN_ACC 8'h4D
`define OPC_ZN_XLOW 8'h5D
`define OPC_ZN_IDXB 8'h6D
`define OPC_ZN_IDX 8'h7D
`define OPC_ZN_STKB 8'h6D
// Moves and compare-and-branch
`define OPC_MOVE_PG_PG 8'h4E
`define OPC_MOVE_PG_IDXPI 8'h5E
`define OPC_MOVE_LIT_PG 8'h6E
`define OPC_MOVE_IDXPI_PG 8'h7E
`define OPC_CMPBR_PAGE 8'h31
`define OPC_CMPBR_IDXBPI 8'h61
`define OPC_CMPBR_IDXPI 8'h71
// Trap and transfers
`define OPC_TRAP 8'h83
`define OPC_A2F 8'h84
`define OPC_F2A 8'h85
`define OPC_A2X 8'h97
`define OPC_X2A 8'h9F
`define OPC_S2HX 8'h95
`define OPC_HX2S 8'h94
// Flag bit positions and bits that always read as one
`define FLAG_V 7
`define FLAG_I 3
`define FLAG_N 2
`define FLAG_Z 1
`define FLAG_C 0
`define FLAG_ONES 8'h60
// Cycle counts per form
`define CYC_ONE 4'd1
`define CYC_TWO 4'd2
`define CYC_LIT 4'd2
`define CYC_PAGE 4'd3
`define CYC_ABS 4'd4
`define CYC_IDXW 4'd4
`define CYC_IDXB 4'd3
`define CYC_IDX 4'd2
`define CYC_STKB 4'd4
`define CYC_STKW 4'd5
`define CYC_TRAP 4'd9
`define CYC_MOVE_LONG 4'd5
`define CYC_MOVE_SHORT 4'd4
`define CYC_CMPBR_LONG 4'd5
`define CYC_CMPBR_SHORT 4'd4
`endif

/* File: cpu_pkg.sv */
// Types shared by the instruction core and its address unit
package cpu_pkg;
    typedef enum logic [2:0] {
        ST_BOOT = 3'b000, ST_OPC = 3'b001, ST_ARG1 = 3'b010, ST_ARG2 = 3'b011,
        ST_MEM = 3'b100, ST_PUSH = 3'b101, ST_VEC = 3'b110, ST_PAD = 3'b111
    } state_e;
    typedef enum logic [3:0] {
        OP_BAD = 4'h0, OP_MINUS = 4'h1, OP_ZNCHECK = 4'h2, OP_MOVE = 4'h3,
        OP_CMPBR = 4'h4, OP_TRAP = 4'h5, OP_A2F = 4'h6, OP_F2A = 4'h7,
        OP_A2X = 4'h8, OP_X2A = 4'h9, OP_S2HX = 4'hA, OP_HX2S = 4'hB
    } op_e;
    typedef enum logic [4:0] {
        AM_INHERENT = 5'h00, AM_LITERAL = 5'h01, AM_PAGE = 5'h02, AM_ABS = 5'h03,
        AM_IDXW = 5'h04, AM_IDXB = 5'h05, AM_IDX = 5'h06, AM_STKB = 5'h07,
        AM_STKW = 5'h08, AM_IDXPI = 5'h09, AM_IDXBPI = 5'h0A, AM_IDXPI_PG = 5'h0B,
        AM_PG_IDXPI = 5'h0C, AM_LIT_PG = 5'h0D, AM_PG_PG = 5'h0E, AM_ACC = 5'h0F,
        AM_XLOW = 5'h10
    } am_e;
    typedef struct packed {
        op_e op;
        am_e am;
        logic [1:0] nargs;
        logic [3:0] cycles;
    } dec_s;
endpackage

/* File: ea_unit.sv */
// Effective address of the operand (or move source) for each form that reads memory; the other forms give zero
module ea_unit (
    input cpu_pkg::am_e am,
    input wire logic [7:0] b1,
    input wire logic [7:0] b2,
    input wire logic [15:0] hx,
    input wire logic [15:0] sp,
    output logic [15:0] ea
);
    import cpu_pkg::*;

    // Offsets are unsigned; sums wrap at 64 KiB like the address bus
    always_comb begin
        unique case (am)
            AM_PAGE, AM_PG_IDXPI, AM_PG_PG: ea = {8'h00, b1};
            AM_ABS: ea = {b1, b2};
            AM_IDXW: ea = hx + {b1, b2};
            AM_IDXB, AM_IDXBPI: ea = hx + {8'h00, b1};
            AM_STKB: ea = sp + {8'h00, b1};
            AM_STKW: ea = sp + {b1, b2};
            AM_IDX, AM_IDXPI, AM_IDXPI_PG: ea = hx;
            default: ea = 16'h0000;
        endcase
    end
endmodule

/* File: cpu_core.sv */
// Instruction core: subtract, trap, zero check, transfers and move forms
`include "cpu_regs.svh"
module cpu_core #(
    parameter logic [15:0] START_PC = 16'h0000,
    parameter logic [15:0] STACK_INIT = 16'h00FF,
    parameter logic [15:0] TRAP_VECTOR = 16'hFFF0
) (
    input wire logic clk_sys,
    input wire logic nrst,
    output logic [15:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic [7:0] acc,
    output logic [15:0] index_pair,
    output logic [15:0] stack_pointer,
    output logic [15:0] prog_counter,
    output logic [7:0] condition_flags,
    output logic instr_done,
    output logic illegal_op,
    output cpu_pkg::state_e core_state
);
    import cpu_pkg::*;

    op_e op, next_op, op_now;
    am_e am, next_am, am_now;
    dec_s dec;
    logic [1:0] nargs, next_nargs;
    logic [3:0] cnt, next_cnt, tgt, next_tgt;
    logic pfx, next_pfx;
    logic [7:0] t1, next_t1, t2, next_t2, arg_b1, arg_b2, opnd;
    logic [2:0] pidx, next_pidx;
    logic [7:0] next_acc, next_ccr, next_wdata;
    logic [15:0] next_idx, next_sp, next_pc, next_addr, ea;
    logic next_rd, next_wr, next_done, next_bad;
    state_e next_state;

    // Table of supported codes; prefix flag is bit 8
    function automatic dec_s decode(input logic [8:0] code);
        dec_s d;
        d = '{OP_BAD, AM_INHERENT, 2'd0, `CYC_ONE};
        case (code)
            {1'b0, `OPC_MINUS_LIT}: d = '{OP_MINUS, AM_LITERAL, 2'd1, `CYC_LIT};
            {1'b0, `OPC_MINUS_PAGE}: d = '{OP_MINUS, AM_PAGE, 2'd1, `CYC_PAGE};
            {1'b0, `OPC_MINUS_ABS}: d = '{OP_MINUS, AM_ABS, 2'd2, `CYC_ABS};
            {1'b0, `OPC_MINUS_IDXW}: d = '{OP_MINUS, AM_IDXW, 2'd2, `CYC_IDXW};
            {1'b0, `OPC_MINUS_IDXB}: d = '{OP_MINUS, AM_IDXB, 2'd1, `CYC_IDXB};
            {1'b0, `OPC_MINUS_IDX}: d = '{OP_MINUS, AM_IDX, 2'd0, `CYC_IDX};
            {1'b1, `OPC_MINUS_STKB}: d = '{OP_MINUS, AM_STKB, 2'd1, `CYC_STKB};
            {1'b1, `OPC_MINUS_STKW}: d = '{OP_MINUS, AM_STKW, 2'd2, `CYC_STKW};
            {1'b0, `OPC_ZN_PAGE}: d = '{OP_ZNCHECK, AM_PAGE, 2'd1, `CYC_PAGE};
            {1'b0, `OPC_ZN_ACC}: d = '{OP_ZNCHECK, AM_ACC, 2'd0, `CYC_ONE};
            {1'b0, `OPC_ZN_XLOW}: d = '{OP_ZNCHECK, AM_XLOW, 2'd0, `CYC_ONE};
            {1'b0, `OPC_ZN_IDXB}: d = '{OP_ZNCHECK, AM_IDXB, 2'd1, `CYC_IDXB};
            {1'b0, `OPC_ZN_IDX}: d = '{OP_ZNCHECK, AM_IDX, 2'd0, `CYC_IDX};
            {1'b1, `OPC_ZN_STKB}: d = '{OP_ZNCHECK, AM_STKB, 2'd1, `CYC_STKB};
            {1'b0, `OPC_MOVE_PG_PG}: d = '{OP_MOVE, AM_PG_PG, 2'd2, `CYC_MOVE_LONG};
            {1'b0, `OPC_MOVE_PG_IDXPI}: d = '{OP_MOVE, AM_PG_IDXPI, 2'd1, `CYC_MOVE_SHORT};
            {1'b0, `OPC_MOVE_LIT_PG}: d = '{OP_MOVE, AM_LIT_PG, 2'd2, `CYC_MOVE_SHORT};
            {1'b0, `OPC_MOVE_IDXPI_PG}: d = '{OP_MOVE, AM_IDXPI_PG, 2'd1, `CYC_MOVE_SHORT};
            {1'b0, `OPC_CMPBR_PAGE}: d = '{OP_CMPBR, AM_PAGE, 2'd2, `CYC_CMPBR_LONG};
            {1'b0, `OPC_CMPBR_IDXBPI}: d = '{OP_CMPBR, AM_IDXBPI, 2'd2, `CYC_CMPBR_LONG};
            {1'b0, `OPC_CMPBR_IDXPI}: d = '{OP_CMPBR, AM_IDXPI, 2'd1, `CYC_CMPBR_SHORT};
            {1'b0, `OPC_TRAP}: d = '{OP_TRAP, AM_INHERENT, 2'd0, `CYC_TRAP};
            {1'b0, `OPC_A2F}: d = '{OP_A2F, AM_INHERENT, 2'd0, `CYC_TWO};
            {1'b0, `OPC_F2A}: d = '{OP_F2A, AM_INHERENT, 2'd0, `CYC_ONE};
            {1'b0, `OPC_A2X}: d = '{OP_A2X, AM_INHERENT, 2'd0, `CYC_ONE};
            {1'b0, `OPC_X2A}: d = '{OP_X2A, AM_INHERENT, 2'd0, `CYC_ONE};
            {1'b0, `OPC_S2HX}: d = '{OP_S2HX, AM_INHERENT, 2'd0, `CYC_TWO};
            {1'b0, `OPC_HX2S}: d = '{OP_HX2S, AM_INHERENT, 2'd0, `CYC_TWO};
            default: d = '{OP_BAD, AM_INHERENT, 2'd0, `CYC_ONE};
        endcase
        return d;
    endfunction

    // Byte pushed at each step of the trap stacking sequence after the first (PC low)
    function automatic logic [7:0] push_byte(input logic [2:0] i, input logic [15:0] pcv,
                                             input logic [7:0] x, input logic [7:0] a,
                                             input logic [7:0] f);
        unique case (i)
            3'd1: push_byte = pcv[15:8];
            3'd2: push_byte = x;
            3'd3: push_byte = a;
            default: push_byte = f;
        endcase
    endfunction

    // Operand bytes as seen this cycle, so an address can be formed the cycle they arrive
    assign dec = decode({pfx, mem_rdata});
    assign op_now = (core_state == ST_OPC) ? dec.op : op;
    assign am_now = (core_state == ST_OPC) ? dec.am : am;
    assign arg_b1 = (core_state == ST_ARG1) ? mem_rdata : t1;
    assign arg_b2 = (core_state == ST_ARG2) ? mem_rdata : t2;
    assign opnd = (core_state == ST_MEM) ? mem_rdata :
                  (am_now == AM_ACC) ? acc :
                  (am_now == AM_XLOW) ? index_pair[7:0] : arg_b1;

    ea_unit u_ea (
        .am(am_now),
        .b1(arg_b1),
        .b2(arg_b2),
        .hx(index_pair),
        .sp(stack_pointer),
        .ea(ea)
    );

    // Sequencer: one bus access per cycle, read data is consumed the cycle it is driven
    always_comb begin
        logic go, exe, fin, fetch;
        logic [7:0] diff, rr;
        go = 1'b0;
        exe = 1'b0;
        fin = 1'b0;
        fetch = 1'b0;
        diff = 8'h00;
        rr = 8'h00;
        next_state = core_state;
        next_op = op;
        next_am = am;
        next_nargs = nargs;
        next_cnt = cnt + 4'd1;
        next_tgt = tgt;
        next_pfx = pfx;
        next_t1 = t1;
        next_t2 = t2;
        next_pidx = pidx;
        next_acc = acc;
        next_ccr = condition_flags;
        next_idx = index_pair;
        next_sp = stack_pointer;
        next_pc = prog_counter;
        next_addr = mem_addr;
        next_rd = 1'b0;
        next_wr = 1'b0;
        next_wdata = mem_wdata;
        next_done = 1'b0;
        next_bad = 1'b0;
        unique case (core_state)
            ST_BOOT: fetch = 1'b1;
            ST_OPC: begin
                next_pc = prog_counter + 16'h0001;
                if (!pfx && mem_rdata == `OPC_PREFIX) begin
                    next_pfx = 1'b1;
                    next_addr = next_pc;
                    next_rd = 1'b1;
                end else begin
                    next_op = dec.op;
                    next_am = dec.am;
                    next_nargs = dec.nargs;
                    next_tgt = dec.cycles;
                    unique case (dec.op)
                        OP_A2F: begin
                            next_ccr = acc | `FLAG_ONES;
                            fin = 1'b1;
                        end
                        OP_F2A: begin
                            next_acc = condition_flags;
                            fin = 1'b1;
                        end
                        OP_A2X: begin
                            next_idx[7:0] = acc;
                            fin = 1'b1;
                        end
                        OP_X2A: begin
                            next_acc = index_pair[7:0];
                            fin = 1'b1;
                        end
                        OP_S2HX: begin
                            next_idx = stack_pointer + 16'h0001;
                            fin = 1'b1;
                        end
                        OP_HX2S: begin
                            next_sp = index_pair - 16'h0001;
                            fin = 1'b1;
                        end
                        OP_TRAP: begin
                            next_addr = stack_pointer;
                            next_wr = 1'b1;
                            next_wdata = next_pc[7:0];
                            next_sp = stack_pointer - 16'h0001;
                            next_pidx = 3'd1;
                            next_state = ST_PUSH;
                        end
                        OP_BAD: begin
                            next_bad = 1'b1;
                            fin = 1'b1;
                        end
                        default: begin
                            if (dec.nargs == 2'd0) begin
                                go = 1'b1;
                            end else begin
                                next_addr = next_pc;
                                next_rd = 1'b1;
                                next_state = ST_ARG1;
                            end
                        end
                    endcase
                end
            end
            ST_ARG1: begin
                next_t1 = mem_rdata;
                next_pc = prog_counter + 16'h0001;
                if (nargs == 2'd2) begin
                    next_addr = next_pc;
                    next_rd = 1'b1;
                    next_state = ST_ARG2;
                end else begin
                    go = 1'b1;
                end
            end
            ST_ARG2: begin
                next_t2 = mem_rdata;
                next_pc = prog_counter + 16'h0001;
                go = 1'b1;
            end
            ST_MEM: exe = 1'b1;
            ST_PUSH: begin
                if (pidx == 3'd5) begin
                    next_ccr[`FLAG_I] = 1'b1;
                    next_addr = TRAP_VECTOR;
                    next_rd = 1'b1;
                    next_pidx = 3'd6;
                    next_state = ST_VEC;
                end else begin
                    next_addr = stack_pointer;
                    next_wr = 1'b1;
                    next_wdata = push_byte(pidx, prog_counter, index_pair[7:0], acc,
                                           condition_flags);
                    next_sp = stack_pointer - 16'h0001;
                    next_pidx = pidx + 3'd1;
                end
            end
            ST_VEC: begin
                if (pidx == 3'd6) begin
                    next_t1 = mem_rdata;
                    next_addr = TRAP_VECTOR + 16'h0001;
                    next_rd = 1'b1;
                    next_pidx = 3'd7;
                end else begin
                    next_pc = {t1, mem_rdata};
                    fin = 1'b1;
                end
            end
            ST_PAD: fetch = (cnt == tgt - 4'd1);
        endcase
        // Operands complete: inline data and the A or X forms execute now, anything else reads memory first
        if (go) begin
            if (am_now == AM_LITERAL || am_now == AM_LIT_PG || am_now == AM_ACC ||
                am_now == AM_XLOW) begin
                exe = 1'b1;
            end else begin
                next_addr = ea;
                next_rd = 1'b1;
                next_state = ST_MEM;
            end
        end
        if (exe) begin
            unique case (op_now)
                OP_MINUS: begin
                    diff = acc - opnd;
                    next_acc = diff;
                    next_ccr[`FLAG_V] = (acc[7] & ~opnd[7] & ~diff[7]) |
                                        (~acc[7] & opnd[7] & diff[7]);
                    next_ccr[`FLAG_C] = (~acc[7] & opnd[7]) | (opnd[7] & diff[7]) |
                                        (diff[7] & ~acc[7]);
                    next_ccr[`FLAG_N] = diff[7];
                    next_ccr[`FLAG_Z] = (diff == 8'h00);
                end
                OP_ZNCHECK: begin
                    next_ccr[`FLAG_V] = 1'b0;
                    next_ccr[`FLAG_N] = opnd[7];
                    next_ccr[`FLAG_Z] = (opnd == 8'h00);
                end
                OP_MOVE: begin
                    next_wr = 1'b1;
                    next_wdata = opnd;
                    unique case (am_now)
                        AM_PG_PG, AM_LIT_PG: next_addr = {8'h00, arg_b2};
                        AM_IDXPI_PG: next_addr = {8'h00, arg_b1};
                        default: next_addr = index_pair;
                    endcase
                end
                OP_CMPBR: begin
                    rr = (am_now == AM_IDXPI) ? arg_b1 : arg_b2;
                    if (acc == opnd) begin
                        next_pc = next_pc + {{8{rr[7]}}, rr};
                    end
                end
                default: ;
            endcase
            // Post-increment only after the access has used the old pointer
            if (am_now == AM_IDXPI || am_now == AM_IDXBPI || am_now == AM_IDXPI_PG ||
                am_now == AM_PG_IDXPI) begin
                next_idx = index_pair + 16'h0001;
            end
            fin = 1'b1;
        end
        // Finished work early pads to the full count so timing never depends on the path
        if (fin) begin
            if (cnt == next_tgt - 4'd1) begin
                fetch = 1'b1;
            end else begin
                next_state = ST_PAD;
            end
        end
        if (fetch) begin
            next_addr = next_pc;
            next_rd = 1'b1;
            next_state = ST_OPC;
            next_cnt = 4'd0;
            next_pfx = 1'b0;
            next_done = (core_state != ST_BOOT);
        end
    end

    // State registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            core_state <= ST_BOOT;
            op <= OP_BAD;
            am <= AM_INHERENT;
            nargs <= 2'd0;
            cnt <= 4'd0;
            tgt <= `CYC_ONE;
            pfx <= 1'b0;
            t1 <= 8'h00;
            t2 <= 8'h00;
            pidx <= 3'd0;
            acc <= 8'h00;
            condition_flags <= `FLAG_ONES;
            index_pair <= 16'h0000;
            stack_pointer <= STACK_INIT;
            prog_counter <= START_PC;
            mem_addr <= 16'h0000;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= 8'h00;
            instr_done <= 1'b0;
            illegal_op <= 1'b0;
        end else begin
            core_state <= next_state;
            op <= next_op;
            am <= next_am;
            nargs <= next_nargs;
            cnt <= next_cnt;
            tgt <= next_tgt;
            pfx <= next_pfx;
            t1 <= next_t1;
            t2 <= next_t2;
            pidx <= next_pidx;
            acc <= next_acc;
            condition_flags <= next_ccr;
            index_pair <= next_idx;
            stack_pointer <= next_sp;
            prog_counter <= next_pc;
            mem_addr <= next_addr;
            mem_rd <= next_rd;
            mem_wr <= next_wr;
            mem_wdata <= next_wdata;
            instr_done <= next_done;
            illegal_op <= next_bad;
        end
    end
endmodule

/* File: mem_model.sv */
// Zero-wait program and data memory on the core's internal bus
module mem_model (
    input wire logic clk_sys,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] m [0:65535];
    logic [7:0] last;
    // Idle bus shows the inverse of the last byte, so a late sample never sees stale data
    assign mem_rdata = mem_rd ? m[mem_addr] : ~last;
    // Writes land on the edge that closes the write cycle
    always @(posedge clk_sys) begin
        if (mem_rd) last <= m[mem_addr];
        if (mem_wr) m[mem_addr] <= mem_wdata;
    end
    // Blank memory reads as an unsupported opcode, which the core skips
    initial begin
        last = 8'h00;
        foreach (m[i]) m[i] = 8'h00;
    end
endmodule

/* File: cpu_core_sva.sv */
// Port-level checks on the instruction core
module cpu_core_sva #(
    parameter logic [15:0] TRAP_VECTOR = 16'hFFF0
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] acc,
    input wire logic [15:0] index_pair,
    input wire logic [15:0] stack_pointer,
    input wire logic [15:0] prog_counter,
    input wire logic [7:0] condition_flags,
    input wire logic instr_done,
    input wire logic illegal_op,
    input cpu_pkg::state_e core_state
);
    import cpu_pkg::*;
    logic fetch;
    // Opcode cycle; operand bytes are fetched in other states
    assign fetch = mem_rd && (core_state == ST_OPC);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_one_access: assert property (!(mem_rd && mem_wr))
        else $error("read and write in one cycle");
    a_trap_pushes: assert property (fetch && mem_rdata == 8'h83 |=> mem_wr [*5] ##1
        (mem_rd && mem_addr == TRAP_VECTOR) ##1 (mem_rd && mem_addr == TRAP_VECTOR + 16'h1))
        else $error("trap push or vector sequence wrong");
    a_trap_mask: assert property (fetch && mem_rdata == 8'h83 |-> ##9 (instr_done &&
        condition_flags[3] && stack_pointer == $past(stack_pointer, 9) - 16'h5))
        else $error("trap did not mask or adjust stack");
    a_sub_literal: assert property (fetch && mem_rdata == 8'hA0 |-> ##2 (instr_done &&
        acc == $past(acc, 2) - $past(mem_rdata) &&
        condition_flags[0] == ($past(acc, 2) < $past(mem_rdata))))
        else $error("literal subtract result or timing wrong");
    a_zn_acc: assert property (fetch && mem_rdata == 8'h4D |=> instr_done &&
        !condition_flags[7] && condition_flags[2] == acc[7] && condition_flags[1] == (acc == 0)
        && condition_flags[0] == $past(condition_flags[0]))
        else $error("accumulator zero check flags wrong");
    a_tax_copy: assert property (fetch && mem_rdata == 8'h97 |=> instr_done &&
        index_pair[7:0] == $past(acc) && $stable(condition_flags))
        else $error("acc to index transfer wrong");
    a_txa_copy: assert property (fetch && mem_rdata == 8'h9F |=>
        instr_done && acc == $past(index_pair[7:0]))
        else $error("index to acc transfer wrong");
    a_tpa_copy: assert property (fetch && mem_rdata == 8'h85 |=>
        instr_done && acc == $past(condition_flags))
        else $error("flags to acc transfer wrong");
    a_tap_load: assert property (fetch && mem_rdata == 8'h84 |-> ##2
        (instr_done && condition_flags == ($past(acc, 2) | 8'h60)))
        else $error("acc to flags transfer wrong");
    a_tsx_plus: assert property (fetch && mem_rdata == 8'h95 |-> ##2
        (instr_done && index_pair == $past(stack_pointer, 2) + 16'h1))
        else $error("stack to index pair transfer wrong");
    a_txs_minus: assert property (fetch && mem_rdata == 8'h94 |-> ##2
        (instr_done && stack_pointer == $past(index_pair, 2) - 16'h1))
        else $error("index pair to stack transfer wrong");
endmodule

/* File: cpu_subtract_transfer_test_ops_tb.sv */
// Self-checking bench: programs in memory, results judged at the core's ports and in memory
module cpu_subtract_transfer_test_ops_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cpu_pkg::*;
    localparam logic [15:0] VEC = 16'hFFF0;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] mem_addr, index_pair, stack_pointer, prog_counter;
    logic mem_rd, mem_wr, instr_done, illegal_op;
    logic [7:0] mem_wdata, mem_rdata, acc, condition_flags;
    state_e core_state;
    int n_fail = 0;
    int num_checks = 0;
    always #20 clk_sys = ~clk_sys;
    cpu_core #(.TRAP_VECTOR(VEC)) i_cpu_core (.clk_sys(clk_sys), .nrst(nrst),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .acc(acc), .index_pair(index_pair),
        .stack_pointer(stack_pointer), .prog_counter(prog_counter),
        .condition_flags(condition_flags), .instr_done(instr_done),
        .illegal_op(illegal_op), .core_state(core_state));
    mem_model i_mem_model (.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    // Counts and reports one comparison
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Reset for six cycles while the program is placed at address zero
    task automatic boot(input logic [7:0] prog [$]);
        @(posedge clk_sys);
        nrst <= 1'b0;
        foreach (prog[i]) i_mem_model.m[i] = prog[i];
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
    endtask
    // Waits for n completions; the extra cycle is the first fetch after reset
    task automatic run(input int n, input int cyc);
        int c;
        int k;
        c = 0;
        k = 0;
        while (k < n && c < 300) begin
            @(posedge clk_sys);
            #1;
            c++;
            if (instr_done === 1'b1) k++;
        end
        if (k < n) begin
            chk(1'b0, "instructions did not complete");
            give_verdict();
        end else chk(c == cyc + 1, "cycle count");
    endtask
    task automatic t_sub();
        i_mem_model.m[16'h0040] = 8'h0F;
        i_mem_model.m[16'h1234] = 8'h10;
        boot('{8'hA0, 8'h01, 8'hB0, 8'h40, 8'hC0, 8'h12, 8'h34});
        run(3, 9);
        chk(acc === 8'hE0 && condition_flags === 8'h64, "subtract chain");
        @(posedge clk_sys);
        #1 chk(illegal_op === 1'b1, "unsupported code");
        $display("subtract forms done");
    endtask
    task automatic t_index();
        i_mem_model.m[16'h0110] = 8'h01;
        i_mem_model.m[16'h0120] = 8'h0F;
        i_mem_model.m[16'h0100] = 8'h10;
        i_mem_model.m[16'h0104] = 8'h20;
        i_mem_model.m[16'h0105] = 8'h40;
        boot('{8'h95, 8'hD0, 8'h00, 8'h10, 8'hE0, 8'h20, 8'hF0,
               8'h9E, 8'hE0, 8'h05, 8'h9E, 8'hD0, 8'h00, 8'h06});
        run(6, 20);
        chk(acc === 8'h80 && index_pair === 16'h0100, "indexed subtract");
        $display("indexed and stack forms done");
    endtask
    task automatic t_trap();
        i_mem_model.m[VEC] = 8'h02;
        i_mem_model.m[VEC + 16'h1] = 8'h00;
        i_mem_model.m[16'h0200] = 8'h4D;
        boot('{8'hA0, 8'h01, 8'h97, 8'h9F, 8'h83});
        run(5, 14);
        chk(i_mem_model.m[16'h00FF] === 8'h05 && i_mem_model.m[16'h00FE] === 8'h00,
            "pc push");
        chk(i_mem_model.m[16'h00FD] === 8'hFF && i_mem_model.m[16'h00FC] === 8'hFF,
            "x a push");
        chk(i_mem_model.m[16'h00FB] === 8'h65 && stack_pointer === 16'h00FA, "flag push");
        chk(condition_flags === 8'h6D && prog_counter === 16'h0201, "after trap");
        $display("trap done");
    endtask
    task automatic t_moves();
        i_mem_model.m[16'h0101] = 8'h77;
        boot('{8'h95, 8'h6E, 8'h55, 8'h30, 8'h4E, 8'h30, 8'h31, 8'h5E, 8'h31, 8'h7E, 8'h32,
               8'h71, 8'h01, 8'h00, 8'h94});
        run(7, 25);
        chk(i_mem_model.m[16'h0030] === 8'h55, "literal to page");
        chk(i_mem_model.m[16'h0031] === 8'h55, "page to page");
        chk(i_mem_model.m[16'h0100] === 8'h55, "page to index");
        chk(i_mem_model.m[16'h0032] === 8'h77, "index to page");
        chk(index_pair === 16'h0103 && stack_pointer === 16'h0102, "hx sp");
        $display("moves done");
    endtask
    task automatic t_zn();
        i_mem_model.m[16'h0040] = 8'h00;
        boot('{8'hA0, 8'h01, 8'h84, 8'h85, 8'h3D, 8'h40});
        run(4, 8);
        chk(acc === 8'hFF && condition_flags === 8'h7B, "flag load and zero check");
        $display("zero check and flag transfers done");
    endtask
    initial begin
        t_sub();
        t_index();
        t_trap();
        t_moves();
        t_zn();
        give_verdict();
    end
endmodule
bind cpu_core cpu_core_sva #(.TRAP_VECTOR(TRAP_VECTOR)) i_cpu_core_sva (.clk_sys(clk_sys),
    .nrst(nrst), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .acc(acc), .index_pair(index_pair),
    .stack_pointer(stack_pointer), .prog_counter(prog_counter),
    .condition_flags(condition_flags), .instr_done(instr_done), .illegal_op(illegal_op),
    .core_state(core_state));
